// *** bench/emsf_xcvr_model.sv ***
/*
 * Line side model for the MAC status block: a transceiver that echoes
 * its own carrier while the MAC transmits and reports link integrity.
 * Assumes the bench picks link state and whether carrier is echoed.
 */
module emsf_xcvr_model
  import emsf_pkg::*;
(
  // Clock.
  input wire logic clk,
  // Controls from the bench.
  input wire logic link_up,
  input wire logic echo_carrier,
  input wire logic tx_active,
  // Transceiver pins.
  output logic carrier_pin,
  output logic link_pin
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    carrier_pin = 1'b0;
    link_pin = 1'b0;
  end

  // Carrier is seen only while our own frame is on the wire.
  always @(posedge clk) begin
    carrier_pin <= echo_carrier & tx_active;
    link_pin <= link_up;
  end
endmodule // emsf_xcvr_model

// *** bench/test_ethernet_mac_status_rx_filter.sv ***
/*
 * Self-checking bench for the MAC status and receive filter block.
 * Assumes the register port and event pulses described in the package.
 */
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end

module test_ethernet_mac_status_rx_filter
  import emsf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk = 1'b0;
  logic reset_n = 1'b0;
  emsf_bus_t bus = '0;
  emsf_evt_t evt = '0;
  emsf_evt_t p;
  logic [47:0] dest_addr = 48'h0;
  logic dest_valid = 1'b0;
  logic table_match = 1'b0;
  logic link_up = 1'b0;
  logic echo_carrier = 1'b1;
  logic carrier_pin, link_pin, transmit_enable, send_jam, tx_abort_no_crc;
  logic rx_flush, rx_store_abort, frame_accept, irq;
  logic [7:0] rdata;
  int failures = 0;
  int checks = 0;
  // Control nibble, group bit, table match bit and expected accept bit.
  logic [15:0] filt [7] = '{16'h0_1_1_1, 16'h0_1_0_0, 16'h4_1_0_1,
                            16'h2_1_0_1, 16'h2_0_0_1, 16'h4_1_1_1,
                            16'h4_0_0_0};

  always #25 clk = ~clk;

  emsf_mac_status DUT (.clk(clk), .reset_n(reset_n), .bus(bus),
    .rdata(rdata), .evt(evt), .dest_addr(dest_addr),
    .dest_valid(dest_valid), .table_match(table_match),
    .carrier_pin(carrier_pin), .link_pin(link_pin),
    .transmit_enable(transmit_enable), .send_jam(send_jam),
    .tx_abort_no_crc(tx_abort_no_crc), .rx_flush(rx_flush),
    .rx_store_abort(rx_store_abort), .frame_accept(frame_accept),
    .irq(irq));

  emsf_xcvr_model xcvr (.clk(clk), .link_up(link_up),
    .echo_carrier(echo_carrier), .tx_active(evt.tx_active),
    .carrier_pin(carrier_pin), .link_pin(link_pin));

  // ************************************************************
  // Register port and event drivers.
  // ************************************************************
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk) bus.wr <= 1'b0;
  endtask

  task automatic rdx(input logic [15:0] a, input logic [7:0] e,
                     input string n);
    @(posedge clk) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk) bus.rd <= 1'b0;
    #1;
    `CHK(n, e, rdata)
  endtask

  task automatic pulse(input emsf_evt_t v);
    @(posedge clk) evt <= evt | v;
    @(posedge clk) evt <= evt & ~v;
    #1;
  endtask

  // Holds a byte strobe high for n edges in a row.
  task automatic burst(input bit tx, input int n);
    @(posedge clk);
    if (tx) evt.tx_byte <= 1'b1;
    else evt.rx_byte <= 1'b1;
    repeat (n) @(posedge clk);
    evt.tx_byte <= 1'b0;
    evt.rx_byte <= 1'b0;
    #1;
  endtask

  task automatic done(input string n);
    $display("test %s finished", n);
  endtask

  // ************************************************************
  // Scenarios.
  // ************************************************************
  task automatic t_reset();
    rdx(EMSF_STATUS_TWO_ADDR, 8'h00, "status two");
    rdx(EMSF_RX_CTRL_ONE_ADDR, 8'h00, "rx control");
    rdx(16'h7fff, 8'h00, "unmapped");
    done("reset");
  endtask

  task automatic t_underrun();
    wr(EMSF_TX_CTRL_ADDR, 8'h01);
    rdx(EMSF_TX_CTRL_ADDR, 8'h01, "tx ctrl");
    wr(EMSF_STATUS_TWO_ADDR, 8'hff);
    rdx(EMSF_STATUS_TWO_ADDR, 8'h00, "status write");
    p = '0;
    p.underrun = 1'b1;
    p.tx_active = 1'b1;
    pulse(p);
    `CHK("tx enable", 1'b0, transmit_enable)
    rdx(EMSF_STATUS_TWO_ADDR, 8'h80, "underrun");
    rdx(EMSF_IRQ_STATUS_ADDR, 8'h08, "tx fail irq");
    wr(EMSF_IRQ_CLEAR_ADDR, 8'h08);
    wr(EMSF_TX_CTRL_ADDR, 8'h01);
    rdx(EMSF_STATUS_TWO_ADDR, 8'h00, "underrun clr");
    done("underrun");
  endtask

  task automatic t_link();
    wr(EMSF_TX_CTRL_ADDR, 8'h04);
    wr(EMSF_IRQ_ENABLE_ADDR, 8'h02);
    link_up <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    `CHK("link irq", 1'b1, irq)
    rdx(EMSF_STATUS_TWO_ADDR, 8'h40, "link up");
    wr(EMSF_IRQ_ENABLE_ADDR, 8'h00);
    rdx(EMSF_IRQ_STATUS_ADDR, 8'h02, "irq status");
    `CHK("masked irq", 1'b0, irq)
    wr(EMSF_IRQ_ENABLE_ADDR, 8'h02);
    wr(EMSF_IRQ_CLEAR_ADDR, 8'h02);
    rdx(EMSF_IRQ_STATUS_ADDR, 8'h00, "irq cleared");
    `CHK("irq low", 1'b0, irq)
    wr(EMSF_TX_CTRL_ADDR, 8'h00);
    link_up <= 1'b0;
    repeat (5) @(posedge clk);
    rdx(EMSF_IRQ_STATUS_ADDR, 8'h00, "link no enable");
    wr(EMSF_TX_CTRL_ADDR, 8'h04);
    link_up <= 1'b1;
    repeat (5) @(posedge clk);
    rdx(EMSF_IRQ_STATUS_ADDR, 8'h02, "link again");
    wr(EMSF_IRQ_CLEAR_ADDR, 8'h02);
    done("link");
  endtask

  task automatic t_overrun();
    wr(EMSF_IRQ_ENABLE_ADDR, 8'h01);
    p = '0;
    p.rx_end = 1'b1;
    pulse(p);
    `CHK("no flush", 1'b0, rx_flush)
    p = '0;
    p.alloc_fail = 1'b1;
    pulse(p);
    `CHK("flush", 1'b1, rx_flush)
    `CHK("overrun irq", 1'b1, irq)
    rdx(EMSF_STATUS_TWO_ADDR, 8'h60, "overrun");
    p = '0;
    p.preamble_ok = 1'b1;
    pulse(p);
    rdx(EMSF_STATUS_TWO_ADDR, 8'h40, "overrun clr");
    rdx(EMSF_IRQ_STATUS_ADDR, 8'h01, "overrun sticky");
    wr(EMSF_IRQ_CLEAR_ADDR, 8'h01);
    rdx(EMSF_IRQ_STATUS_ADDR, 8'h00, "overrun acked");
    done("overrun");
  endtask

  task automatic t_rollover();
    p = '0;
    p.tx_end = 1'b1;
    p.single_col = 1'b1;
    repeat (14) pulse(p);
    rdx(EMSF_STATUS_TWO_ADDR, 8'h40, "below max");
    pulse(p);
    rdx(EMSF_STATUS_TWO_ADDR, 8'h50, "rollover");
    rdx(EMSF_COUNTER_ADDR, 8'h0f, "counters");
    rdx(EMSF_STATUS_TWO_ADDR, 8'h40, "rollover clr");
    p = '0;
    p.tx_end = 1'b1;
    p.multi_col = 1'b1;
    pulse(p);
    rdx(EMSF_COUNTER_ADDR, 8'h1f, "multi count");
    done("rollover");
  endtask

  task automatic t_deferral();
    @(posedge clk) evt.deferring <= 1'b1;
    repeat (EMSF_DEFER_BYTES * EMSF_BYTE_CYCLES - 20) @(posedge clk);
    rdx(EMSF_STATUS_TWO_ADDR, 8'h40, "defer short");
    repeat (40) @(posedge clk);
    rdx(EMSF_STATUS_TWO_ADDR, 8'h48, "defer long");
    @(posedge clk) evt.deferring <= 1'b0;
    p = '0;
    p.tx_end = 1'b1;
    pulse(p);
    rdx(EMSF_STATUS_TWO_ADDR, 8'h40, "defer clr");
    done("deferral");
  endtask

  task automatic t_carrier();
    wr(EMSF_TX_CTRL_ADDR, 8'h03);
    p = '0;
    p.tx_preamble_end = 1'b1;
    for (int k = 1; k >= 0; k--) begin
      echo_carrier <= k[0];
      @(posedge clk) evt.tx_active <= 1'b1;
      repeat (5) @(posedge clk);
      pulse(p);
      `CHK("no crc abort", ~k[0], tx_abort_no_crc)
      `CHK("tx enable", k[0], transmit_enable)
      @(posedge clk) evt.tx_active <= 1'b0;
    end
    echo_carrier <= 1'b1;
    rdx(EMSF_STATUS_TWO_ADDR, 8'h44, "carrier lost");
    wr(EMSF_TX_CTRL_ADDR, 8'h01);
    rdx(EMSF_STATUS_TWO_ADDR, 8'h40, "carrier clr");
    done("carrier");
  endtask

  task automatic t_latecol();
    @(posedge clk) evt.tx_active <= 1'b1;
    burst(1'b1, EMSF_LATE_COL_BYTES);
    p = '0;
    p.collision = 1'b1;
    pulse(p);
    `CHK("early jam", 1'b0, send_jam)
    burst(1'b1, 1);
    pulse(p);
    `CHK("late jam", 1'b1, send_jam)
    `CHK("tx enable", 1'b0, transmit_enable)
    @(posedge clk) evt.tx_active <= 1'b0;
    rdx(EMSF_STATUS_TWO_ADDR, 8'h42, "late col");
    wr(EMSF_TX_CTRL_ADDR, 8'h01);
    rdx(EMSF_STATUS_TWO_ADDR, 8'h40, "late col clr");
    done("late collision");
  endtask

  task automatic t_filter();
    logic [7:0] ctl;
    foreach (filt[i]) begin
      ctl = {4'h0, filt[i][15:12]};
      wr(EMSF_RX_CTRL_ONE_ADDR, ctl);
      rdx(EMSF_RX_CTRL_ONE_ADDR, ctl, "rx control");
      @(posedge clk);
      dest_addr <= {7'h00, filt[i][8], 40'h12_3456_789a};
      table_match <= filt[i][4];
      dest_valid <= 1'b1;
      @(posedge clk) dest_valid <= 1'b0;
      #1;
      `CHK("accept", filt[i][0], frame_accept)
    end
    done("filter");
  endtask

  task automatic t_oversize();
    wr(EMSF_RX_CTRL_ONE_ADDR, 8'h00);
    wr(EMSF_IRQ_ENABLE_ADDR, 8'h04);
    p = '0;
    p.preamble_ok = 1'b1;
    pulse(p);
    burst(1'b0, EMSF_MAX_FRAME_BYTES);
    `CHK("max frame", 1'b0, rx_store_abort)
    burst(1'b0, 1);
    `CHK("oversize", 1'b1, rx_store_abort)
    p = '0;
    p.rx_end = 1'b1;
    pulse(p);
    `CHK("abort irq", 1'b1, irq)
    wr(EMSF_RX_CTRL_ONE_ADDR, 8'h01);
    rdx(EMSF_RX_CTRL_ONE_ADDR, 8'h01, "abort flag");
    wr(EMSF_RX_CTRL_ONE_ADDR, 8'h00);
    rdx(EMSF_RX_CTRL_ONE_ADDR, 8'h00, "abort acked");
    rdx(EMSF_IRQ_STATUS_ADDR, 8'h0c, "irq pending");
    wr(EMSF_IRQ_CLEAR_ADDR, 8'h0c);
    rdx(EMSF_IRQ_STATUS_ADDR, 8'h00, "irq idle");
    done("oversize");
  endtask

  // ************************************************************
  // Sequence, watchdog and verdict.
  // ************************************************************
  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_underrun();
    t_link();
    t_overrun();
    t_rollover();
    t_deferral();
    t_carrier();
    t_latecol();
    t_filter();
    t_oversize();
    stop_test();
  end

  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    stop_test();
  end
endmodule // test_ethernet_mac_status_rx_filter

// *** design/emsf_mac_status.sv ***
/*
 * MAC status register two, receive control register one, the address
 * filter decision, transmit enable control and the statistics counters.
 * Assumes events come from MAC logic on the same clock; the carrier and
 * link pins come from the transceiver and are synchronised here.
 */
// Chosen here: strobed register access.
//
// Summary of operation
// - Underrun sets bit 7, drops transmit enable.
// - Bit 6 shows link; changes raise interrupt.
// - Overrun sets bit 5, flushes, stays enabled.
// - Valid preamble clears the overrun flag.
// - Overrun sets sticky interrupt until software clears.
// - Overrun only when memory allocation failed.
// - Counter at 15 sets bit 4; read clears.
// - Deferral over 3036 byte times sets bit 3.
// - No carrier at preamble end sets bit 2.
// - Collision after more than 64 bytes: jam, bit 1.
// - Bit 0 of status two reads zero.
// - All-group bit accepts every multicast frame.
// - Promiscuous bit accepts every frame.
// - Frames over 1532 bytes aborted, flag set.
// - Abort flag clears on reset or zero write.
// - Missing carrier aborts transmit without CRC.
// - Counters advance once per transmit packet with collisions.
module emsf_mac_status
  import emsf_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Register port.
  input wire emsf_bus_t bus,
  output logic [7:0] rdata,
  // MAC events on the system clock.
  input wire emsf_evt_t evt,
  input wire logic [47:0] dest_addr,
  input wire logic dest_valid,
  input wire logic table_match,
  // Transceiver pins.
  input wire logic carrier_pin,
  input wire logic link_pin,
  // Outputs to the MAC.
  output logic transmit_enable,
  output logic send_jam,
  output logic tx_abort_no_crc,
  output logic rx_flush,
  output logic rx_store_abort,
  output logic frame_accept,
  output logic irq
);

  typedef struct packed {
    logic [1:0] carr_sync;
    logic [1:0] link_sync;
    logic link_prev;
    logic transmit_underrun_flag;
    logic receive_overrun_flag;
    logic counter_rollover_flag;
    logic excessive_deferral_flag;
    logic carrier_lost_flag;
    logic late_collision_flag;
    logic accept_all_group_frames;
    logic accept_every_frame;
    logic rx_abort_flag;
    logic transmit_enable;
    logic carrier_monitor_enable;
    logic link_event_irq_enable;
    logic [3:0] irq_status;
    logic [3:0] irq_enable;
    logic [3:0] single_count;
    logic [3:0] multi_count;
    logic [10:0] rx_len;
    logic [11:0] defer_len;
    logic [6:0] tx_len;
    logic [4:0] byte_div;
    logic counted;
    logic jam;
    logic abort;
    logic flush;
    logic drop;
    logic accept;
    logic [7:0] rdata;
  } emsf_state_t;

  emsf_state_t s_r, s_nxt;
  logic carrier_ok;
  logic link_ok;

  assign carrier_ok = s_r.carr_sync[1];
  assign link_ok = s_r.link_sync[1];

  always_comb begin
    logic [7:0] status_two;
    logic byte_tick;
    logic [3:0] events;
    s_nxt = s_r;
    status_two = EMSF_RESET_BYTE;
    byte_tick = 1'b0;
    events = 4'h0;
    s_nxt.carr_sync = {s_r.carr_sync[0], carrier_pin};
    s_nxt.link_sync = {s_r.link_sync[0], link_pin};
    s_nxt.link_prev = link_ok;
    s_nxt.jam = 1'b0;
    s_nxt.abort = 1'b0;
    s_nxt.flush = 1'b0;
    s_nxt.drop = 1'b0;

    // Byte-time enable used to measure deferral in byte times.
    if (s_r.byte_div == 5'(EMSF_BYTE_CYCLES - 1)) begin
      s_nxt.byte_div = 5'h0;
      byte_tick = 1'b1;
    end else begin
      s_nxt.byte_div = s_r.byte_div + 5'h1;
    end

    // Status register two read view; bit 0 stays zero.
    status_two[EMSF_UNDERRUN_BIT] = s_r.transmit_underrun_flag;
    status_two[EMSF_LINK_BIT] = link_ok;
    status_two[EMSF_OVERRUN_BIT] = s_r.receive_overrun_flag;
    status_two[EMSF_ROLLOVER_BIT] = s_r.counter_rollover_flag;
    status_two[EMSF_DEFERRAL_BIT] = s_r.excessive_deferral_flag;
    status_two[EMSF_CARRIER_BIT] = s_r.carrier_lost_flag;
    status_two[EMSF_LATECOL_BIT] = s_r.late_collision_flag;

    // Register writes; status two has no write path.
    if (bus.wr) begin
      unique case (bus.addr)
        EMSF_RX_CTRL_ONE_ADDR: begin
          s_nxt.accept_all_group_frames = bus.wdata[EMSF_ALL_GROUP_BIT];
          s_nxt.accept_every_frame = bus.wdata[EMSF_ALL_FRAME_BIT];
          if (!bus.wdata[EMSF_ABORT_BIT]) begin
            s_nxt.rx_abort_flag = 1'b0;
          end
        end
        EMSF_TX_CTRL_ADDR: begin
          s_nxt.transmit_enable = bus.wdata[EMSF_TX_ENABLE_BIT];
          s_nxt.carrier_monitor_enable = bus.wdata[EMSF_CARR_MON_BIT];
          s_nxt.link_event_irq_enable = bus.wdata[EMSF_LINK_IRQ_EN_BIT];
          if (bus.wdata[EMSF_TX_ENABLE_BIT]) begin
            s_nxt.transmit_underrun_flag = 1'b0;
            s_nxt.carrier_lost_flag = 1'b0;
            s_nxt.late_collision_flag = 1'b0;
          end
        end
        EMSF_IRQ_CLEAR_ADDR: begin
          s_nxt.irq_status = s_r.irq_status & ~bus.wdata[3:0];
        end
        EMSF_IRQ_ENABLE_ADDR: begin
          s_nxt.irq_enable = bus.wdata[3:0];
        end
        default: begin
        end
      endcase
    end

    // Register reads; the counter read clears the rollover flag.
    s_nxt.rdata = EMSF_RESET_BYTE;
    if (bus.rd) begin
      unique case (bus.addr)
        EMSF_STATUS_TWO_ADDR: s_nxt.rdata = status_two;
        EMSF_RX_CTRL_ONE_ADDR: s_nxt.rdata = {5'h0,
          s_r.accept_all_group_frames, s_r.accept_every_frame,
          s_r.rx_abort_flag};
        EMSF_TX_CTRL_ADDR: s_nxt.rdata = {5'h0,
          s_r.link_event_irq_enable, s_r.carrier_monitor_enable,
          s_r.transmit_enable};
        EMSF_IRQ_STATUS_ADDR: s_nxt.rdata = {4'h0, s_r.irq_status};
        EMSF_IRQ_ENABLE_ADDR: s_nxt.rdata = {4'h0, s_r.irq_enable};
        EMSF_COUNTER_ADDR: begin
          s_nxt.rdata = {s_r.multi_count, s_r.single_count};
          s_nxt.counter_rollover_flag = 1'b0;
        end
        default: s_nxt.rdata = EMSF_RESET_BYTE;
      endcase
    end

    // Transmit side hardware events; these win over software writes.
    if (evt.underrun && evt.tx_active) begin
      s_nxt.transmit_underrun_flag = 1'b1;
      s_nxt.transmit_enable = 1'b0;
      events[EMSF_IRQ_TXFAIL] = 1'b1;
    end
    if (evt.tx_preamble_end && s_r.carrier_monitor_enable
        && !carrier_ok) begin
      s_nxt.carrier_lost_flag = 1'b1;
      s_nxt.transmit_enable = 1'b0;
      s_nxt.abort = 1'b1;
      events[EMSF_IRQ_TXFAIL] = 1'b1;
    end
    if (evt.tx_active && s_r.carrier_monitor_enable && !carrier_ok
        && s_r.tx_len != 7'h0) begin
      s_nxt.abort = 1'b1;
    end
    if (!evt.tx_active) begin
      s_nxt.tx_len = 7'h0;
    end else if (evt.tx_byte && s_r.tx_len != 7'h7f) begin
      s_nxt.tx_len = s_r.tx_len + 7'h1;
    end
    if (evt.collision && evt.tx_active
        && s_r.tx_len > 7'(EMSF_LATE_COL_BYTES)) begin
      s_nxt.late_collision_flag = 1'b1;
      s_nxt.transmit_enable = 1'b0;
      s_nxt.jam = 1'b1;
      events[EMSF_IRQ_TXFAIL] = 1'b1;
    end

    // Deferral measured in byte times; end of packet clears it.
    if (!evt.deferring) begin
      s_nxt.defer_len = 12'h0;
    end else if (byte_tick && s_r.defer_len != 12'hfff) begin
      s_nxt.defer_len = s_r.defer_len + 12'h1;
    end
    if (evt.tx_end) begin
      s_nxt.excessive_deferral_flag = 1'b0;
    end
    if (evt.deferring && s_r.defer_len > 12'(EMSF_DEFER_BYTES)) begin
      s_nxt.excessive_deferral_flag = 1'b1;
    end

    // Statistics counters: one step per packet at most.
    if (evt.tx_end && !s_r.counted) begin
      s_nxt.counted = 1'b1;
      if (evt.single_col) begin
        s_nxt.single_count = s_r.single_count + 4'h1;
        if (s_r.single_count + 4'h1 == EMSF_COUNT_MAX) begin
          s_nxt.counter_rollover_flag = 1'b1;
        end
      end else if (evt.multi_col) begin
        s_nxt.multi_count = s_r.multi_count + 4'h1;
        if (s_r.multi_count + 4'h1 == EMSF_COUNT_MAX) begin
          s_nxt.counter_rollover_flag = 1'b1;
        end
      end
    end else if (!evt.tx_end) begin
      s_nxt.counted = 1'b0;
    end

    // Receive side: preamble clears overrun, overrun needs failed alloc.
    if (evt.preamble_ok) begin
      s_nxt.receive_overrun_flag = 1'b0;
      s_nxt.rx_len = 11'h0;
    end
    if (evt.alloc_fail) begin
      s_nxt.receive_overrun_flag = 1'b1;
      s_nxt.flush = 1'b1;
      events[EMSF_IRQ_OVERRUN] = 1'b1;
    end
    if (evt.rx_byte && s_r.rx_len != 11'h7ff) begin
      s_nxt.rx_len = s_r.rx_len + 11'h1;
      if (s_r.rx_len == 11'(EMSF_MAX_FRAME_BYTES)) begin
        s_nxt.rx_abort_flag = 1'b1;
        s_nxt.drop = 1'b1;
        events[EMSF_IRQ_ABORT] = 1'b1;
      end
    end
    if (evt.rx_end) begin
      s_nxt.rx_len = 11'h0;
    end

    // Address filter decision.
    s_nxt.accept = 1'b0;
    if (dest_valid) begin
      if (s_r.accept_every_frame) begin
        s_nxt.accept = 1'b1;
      end else if (dest_addr[40]) begin
        s_nxt.accept = s_r.accept_all_group_frames || table_match;
      end else begin
        s_nxt.accept = table_match;
      end
    end

    // Link change interrupt.
    if (link_ok != s_r.link_prev && s_r.link_event_irq_enable) begin
      events[EMSF_IRQ_LINK] = 1'b1;
    end
    s_nxt.irq_status = s_nxt.irq_status | events;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata = s_r.rdata;
  assign transmit_enable = s_r.transmit_enable;
  assign send_jam = s_r.jam;
  assign tx_abort_no_crc = s_r.abort;
  assign rx_flush = s_r.flush;
  assign rx_store_abort = s_r.drop;
  assign frame_accept = s_r.accept;
  assign irq = |(s_r.irq_status & s_r.irq_enable);

  // ************************************************************
  // Checks.
  // ************************************************************
  a_underrun_drops_enable: assert property (@(posedge clk)
    disable iff (!reset_n) evt.underrun && evt.tx_active
    |=> s_r.transmit_underrun_flag && !transmit_enable)
    else $error("underrun did not set flag and drop enable");

  a_overrun_cause: assert property (@(posedge clk)
    disable iff (!reset_n) $rose(s_r.receive_overrun_flag)
    |-> $past(evt.alloc_fail))
    else $error("overrun flag rose without allocation failure");

  a_overrun_irq_sticky: assert property (@(posedge clk)
    disable iff (!reset_n) evt.alloc_fail ##1 !(bus.wr
    && bus.addr == EMSF_IRQ_CLEAR_ADDR)[*2]
    |-> s_r.irq_status[EMSF_IRQ_OVERRUN])
    else $error("overrun interrupt status lost");

  a_preamble_clears: assert property (@(posedge clk)
    disable iff (!reset_n) evt.preamble_ok && !evt.alloc_fail
    |=> !s_r.receive_overrun_flag)
    else $error("preamble did not clear overrun flag");

  a_abort_hold: assert property (@(posedge clk)
    disable iff (!reset_n) $fell(s_r.rx_abort_flag)
    |-> $past(bus.wr && bus.addr == EMSF_RX_CTRL_ONE_ADDR))
    else $error("abort flag cleared without a write");

  a_status_bit0_zero: assert property (@(posedge clk)
    disable iff (!reset_n) $past(bus.rd && bus.addr == EMSF_STATUS_TWO_ADDR)
    |-> !rdata[0])
    else $error("status bit 0 read as one");

  a_promisc_accept: assert property (@(posedge clk)
    disable iff (!reset_n) dest_valid && s_r.accept_every_frame
    |=> frame_accept)
    else $error("promiscuous frame not accepted");

  a_late_col_jam: assert property (@(posedge clk)
    disable iff (!reset_n) evt.collision && evt.tx_active
    && s_r.tx_len > 7'(EMSF_LATE_COL_BYTES)
    |=> send_jam && s_r.late_collision_flag ##1 !send_jam)
    else $error("late collision did not jam once");

  a_link_irq: assert property (@(posedge clk)
    disable iff (!reset_n) link_ok != s_r.link_prev
    && s_r.link_event_irq_enable |=> s_r.irq_status[EMSF_IRQ_LINK])
    else $error("link change did not raise interrupt");

  a_carrier_lost_stop: assert property (@(posedge clk)
    disable iff (!reset_n) evt.tx_preamble_end
    && s_r.carrier_monitor_enable && !carrier_ok
    |=> s_r.carrier_lost_flag && !transmit_enable)
    else $error("missing carrier did not stop transmit");

  a_no_crc_abort: assert property (@(posedge clk)
    disable iff (!reset_n) evt.tx_preamble_end
    && s_r.carrier_monitor_enable && !carrier_ok |=> tx_abort_no_crc)
    else $error("missing carrier did not abort the frame");

  a_deferral_flag_set: assert property (@(posedge clk)
    disable iff (!reset_n) evt.deferring
    && s_r.defer_len > 12'(EMSF_DEFER_BYTES)
    |=> s_r.excessive_deferral_flag)
    else $error("long deferral did not set the flag");

  a_oversize_abort: assert property (@(posedge clk)
    disable iff (!reset_n) evt.rx_byte
    && s_r.rx_len == 11'(EMSF_MAX_FRAME_BYTES)
    |=> rx_store_abort && s_r.rx_abort_flag)
    else $error("oversize frame was not aborted");

  a_rollover_read_clear: assert property (@(posedge clk)
    disable iff (!reset_n) bus.rd && bus.addr == EMSF_COUNTER_ADDR
    && !evt.tx_end |=> !s_r.counter_rollover_flag)
    else $error("counter read did not clear rollover");

  a_status_write_ignored: assert property (@(posedge clk)
    disable iff (!reset_n) bus.wr && bus.addr == EMSF_STATUS_TWO_ADDR
    && evt == '0 |=> $stable({s_r.transmit_underrun_flag,
    s_r.receive_overrun_flag, s_r.counter_rollover_flag,
    s_r.excessive_deferral_flag, s_r.carrier_lost_flag,
    s_r.late_collision_flag}))
    else $error("write changed status register two");

endmodule // emsf_mac_status

// *** design/emsf_pkg.sv ***
/*
 * Package for the MAC status and receive filter block: register offsets,
 * bit positions, reset values, timing counts and the bus and event structs.
 * Assumes a 20 MHz system clock and a byte-wide register port.
 */
package emsf_pkg;

  // ************************************************************
  // Register map.
  // ************************************************************
  localparam logic [15:0] EMSF_STATUS_TWO_ADDR = 16'h7fd3;
  localparam logic [15:0] EMSF_RX_CTRL_ONE_ADDR = 16'h7fd4;
  localparam logic [15:0] EMSF_TX_CTRL_ADDR = 16'h7f00;
  localparam logic [15:0] EMSF_IRQ_STATUS_ADDR = 16'h7f01;
  localparam logic [15:0] EMSF_IRQ_CLEAR_ADDR = 16'h7f02;
  localparam logic [15:0] EMSF_IRQ_ENABLE_ADDR = 16'h7f03;
  localparam logic [15:0] EMSF_COUNTER_ADDR = 16'h7f04;

  // ************************************************************
  // Status register two bit positions.
  // ************************************************************
  localparam int EMSF_UNDERRUN_BIT = 7;
  localparam int EMSF_LINK_BIT = 6;
  localparam int EMSF_OVERRUN_BIT = 5;
  localparam int EMSF_ROLLOVER_BIT = 4;
  localparam int EMSF_DEFERRAL_BIT = 3;
  localparam int EMSF_CARRIER_BIT = 2;
  localparam int EMSF_LATECOL_BIT = 1;

  // Receive control one bit positions.
  localparam int EMSF_ALL_GROUP_BIT = 2;
  localparam int EMSF_ALL_FRAME_BIT = 1;
  localparam int EMSF_ABORT_BIT = 0;

  // Own transmit control bit positions.
  localparam int EMSF_TX_ENABLE_BIT = 0;
  localparam int EMSF_CARR_MON_BIT = 1;
  localparam int EMSF_LINK_IRQ_EN_BIT = 2;

  // Interrupt status bit positions.
  localparam int EMSF_IRQ_OVERRUN = 0;
  localparam int EMSF_IRQ_LINK = 1;
  localparam int EMSF_IRQ_ABORT = 2;
  localparam int EMSF_IRQ_TXFAIL = 3;

  localparam logic [7:0] EMSF_RESET_BYTE = 8'h00;

  // ************************************************************
  // Byte-time limits.
  // ************************************************************
  localparam int EMSF_MAX_FRAME_BYTES = 1532;
  localparam int EMSF_DEFER_BYTES = 1518 * 2;
  localparam int EMSF_LATE_COL_BYTES = 64;
  localparam int EMSF_CLK_HZ = 20_000_000;
  localparam int EMSF_BYTE_NS = 800;
  localparam int EMSF_BYTE_CYCLES = (EMSF_BYTE_NS * (EMSF_CLK_HZ / 1_000_000)
                                     + 999) / 1000;
  localparam logic [3:0] EMSF_COUNT_MAX = 4'hf;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } emsf_bus_t;

  typedef struct packed {
    logic underrun;
    logic alloc_fail;
    logic preamble_ok;
    logic rx_byte;
    logic rx_end;
    logic tx_active;
    logic tx_byte;
    logic tx_preamble_end;
    logic tx_end;
    logic deferring;
    logic collision;
    logic single_col;
    logic multi_col;
  } emsf_evt_t;

endpackage : emsf_pkg
